//--- common/pmw_if.sv
/*
  Data-space bus between the CPU core end and the data ROM window end.
  Assumes both ends run on the same core clock; no clocking here.
*/
`default_nettype none
interface pmw_if;
  logic [7:0] ds_addr;    // Data-space address
  logic ds_wr;            // Write strobe, one cycle
  logic ds_rd;            // Read strobe, one cycle
  logic [7:0] ds_wdata;   // Write data
  logic [7:0] ds_rdata;   // Read data, valid with ds_rvalid
  logic ds_rvalid;        // Read answer, one cycle
  modport dev (input ds_addr, ds_wr, ds_rd, ds_wdata, output ds_rdata, ds_rvalid);
  modport cpu (output ds_addr, ds_wr, ds_rd, ds_wdata, input ds_rdata, ds_rvalid);
endinterface
`default_nettype wire

//--- common/pmw_pkg.sv
/*
  Constants shared by both ends of the data ROM window: data-space addresses,
  field positions of the block-select register and of the option word,
  and the widths of the program-memory address.
  Assumes an 8-bit data space and a 12-bit program-memory address.
*/
`default_nettype none
package pmw_pkg;
  localparam int DS_AW = 8;                     // Data-space address width
  localparam int DW = 8;                        // Data width
  localparam int BLK_W = 6;                     // Block number width
  localparam int OFS_W = 6;                     // Offset within a block
  localparam int PM_AW = BLK_W + OFS_W;         // Program-memory address width
  localparam int OPT_W = 16;                    // Two option bytes
  localparam logic [7:0] WIN_LO = 8'h40;        // First window location
  localparam logic [7:0] WIN_HI = 8'h7F;        // Last window location
  localparam logic [7:0] BLKSEL_ADDR = 8'hC9;   // Block-select register
  localparam logic [1:0] BLKSEL_RSVD = 2'h0;    // Value of bits 7:6 on writes
  localparam logic [7:0] RD_NONE = 8'h00;       // Read data outside the window
  localparam logic [15:0] OPT_DEFAULT = 16'h0000; // Delivered option content
  localparam int OPT_STOP_WDG = 9;              // Stop allowed with watchdog
  localparam int OPT_LVD = 8;                   // Low-voltage detector
  localparam int OPT_PROTECT = 7;               // Readout protection
  localparam int OPT_OSC_RC = 6;                // Oscillator is RC network
  localparam int OPT_NMI_PU = 3;                // Pull-up on the NMI pin
  localparam int OPT_WDG_HW = 1;                // Hardware watchdog
  localparam int OPT_OSG = 0;                   // Oscillator safeguard
endpackage
`default_nettype wire

//--- hdl/pmw_cpu.sv
/*
  CPU core end of the data ROM window: turns block-select and byte-read
  commands into data-space accesses, keeping a RAM image of the selection.
  Assumes the window end answers every read with ds_rvalid.
*/
`default_nettype none
module pmw_cpu (
  input wire logic core_clk,
  input wire logic arst_n,
  pmw_if.cpu bus,
  input wire logic cmd_valid,
  input wire logic cmd_sel,
  input wire logic [pmw_pkg::BLK_W-1:0] cmd_arg,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic [pmw_pkg::DW-1:0] rsp_data,
  output logic rsp_err,
  output logic [pmw_pkg::BLK_W-1:0] blk_image
);
  typedef enum logic [2:0] {PMW_IDLE, PMW_WRITE, PMW_READ, PMW_WAIT} pmw_state_t;
  pmw_state_t state_q;
  logic image_ok_q; // Image and register have been written since reset

  // Command sequencer; reads never target the block select, only the window
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= PMW_IDLE;
      cmd_ready <= 1'b1;
      image_ok_q <= 1'b0;
      blk_image <= '0;
      bus.ds_addr <= '0;
      bus.ds_wr <= 1'b0;
      bus.ds_rd <= 1'b0;
      bus.ds_wdata <= '0;
      rsp_valid <= 1'b0;
      rsp_data <= '0;
      rsp_err <= 1'b0;
    end else begin
      bus.ds_wr <= 1'b0;
      bus.ds_rd <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_err <= 1'b0;
      unique case (state_q)
        PMW_IDLE: begin
          if (cmd_valid && cmd_sel) begin
            // Image first, so an interruption never leaves it stale
            blk_image <= cmd_arg;
            cmd_ready <= 1'b0;
            state_q <= PMW_WRITE;
          end else if (cmd_valid && !image_ok_q) begin
            rsp_valid <= 1'b1; // No block chosen yet: refuse the read
            rsp_err <= 1'b1;
          end else if (cmd_valid) begin
            cmd_ready <= 1'b0;
            state_q <= PMW_READ;
            bus.ds_rd <= 1'b1;
            bus.ds_addr <= pmw_pkg::WIN_LO | {2'h0, cmd_arg};
          end
        end
        PMW_WRITE: begin
          bus.ds_wr <= 1'b1; // Whole write, never read-modify-write
          bus.ds_addr <= pmw_pkg::BLKSEL_ADDR;
          bus.ds_wdata <= {pmw_pkg::BLKSEL_RSVD, blk_image};
          image_ok_q <= 1'b1;
          cmd_ready <= 1'b1;
          state_q <= PMW_IDLE;
        end
        PMW_READ: begin
          state_q <= PMW_WAIT;
        end
        PMW_WAIT: begin
          if (bus.ds_rvalid) begin
            rsp_valid <= 1'b1;
            rsp_data <= bus.ds_rdata;
            cmd_ready <= 1'b1;
            state_q <= PMW_IDLE;
          end
        end
      endcase
    end
  end
endmodule
`default_nettype wire

//--- hdl/pmw_window.sv
/*
  Data ROM window end: block-select register, window decode onto program
  memory, and the one-time option word with its decoded configuration.
  Assumes program memory reads combinationally from pm_addr, and that the
  programming-voltage detector gives a clean synchronous level.
*/
`default_nettype none
// Function
// - Window 40h-7Fh reads selected program block
// - Block-select at 0C9h, write only
// - Block-select not reset; software writes first
// - Bits 5:0 upper address; 7:6 zero
// - Software never reads or modifies block-select
// - Software loads block, then reads offset
// - Interrupt code keeps RAM image first
// - Programming mode only with programming voltage
// - Options unaddressed; reachable only when programming
// - Options programmable once only
// - Delivered programmable parts hold zero options
// - Factory-coded parts: options unreadable
// - Option 9 gates stop under watchdog
// - Option 8 enables low-voltage detector
// - Option 7 blocks external readout
// - Option 6 selects RC oscillator
// - Option 3 enables NMI pull-up
// - Option 1 forces watchdog on
// - Option 0 enables oscillator safeguard
// - Blocks step by 64 bytes from zero
module pmw_window #(
  parameter bit FACTORY_CODED = 1'b0,              // Options fixed by mask
  parameter logic [15:0] MASK_OPTIONS = 16'h0000   // Mask options, plain default
) (
  input wire logic core_clk,
  input wire logic arst_n,
  pmw_if.dev bus,
  output logic [pmw_pkg::PM_AW-1:0] pm_addr,
  input wire logic [pmw_pkg::DW-1:0] pm_rdata,
  input wire logic vpp_high,
  input wire logic opt_wr,
  input wire logic [pmw_pkg::OPT_W-1:0] opt_wdata,
  input wire logic opt_rd,
  output logic [pmw_pkg::OPT_W-1:0] opt_rdata,
  output logic opt_rvalid,
  output logic opt_locked,
  input wire logic ext_rd,
  input wire logic [pmw_pkg::PM_AW-1:0] ext_addr,
  output logic [pmw_pkg::DW-1:0] ext_rdata,
  output logic ext_rvalid,
  input wire logic wdg_active,
  input wire logic nmi_pin,
  output logic stop_allowed,
  output logic lvd_en,
  output logic readout_protect,
  output logic osc_rc,
  output logic nmi_pullup,
  output logic wdg_hw,
  output logic osg_en
);
  logic [pmw_pkg::BLK_W-1:0] blk_q;     // Selected block, no reset
  logic rd_pend_q;                      // Window read waiting for memory
  logic ext_pend_q;                     // External read waiting for memory
  logic [pmw_pkg::OPT_W-1:0] opt_q;     // Programmed option word
  logic prog_q;                         // Option word already programmed
  logic [pmw_pkg::OPT_W-1:0] opt_eff;   // Options in force
  logic prog_mode;                      // Memory programming mode

  // Window hit decode, used for both the read path and its check
  function automatic logic in_window(input logic [7:0] a);
    in_window = (a >= pmw_pkg::WIN_LO) && (a <= pmw_pkg::WIN_HI);
  endfunction

  assign prog_mode = vpp_high;
  // Mask parts ignore the programmable word entirely
  assign opt_eff = FACTORY_CODED ? MASK_OPTIONS : opt_q;

  // Block select: kept without reset, so it stays undefined until written
  always_ff @(posedge core_clk) begin
    if (bus.ds_wr && bus.ds_addr == pmw_pkg::BLKSEL_ADDR) begin
      blk_q <= bus.ds_wdata[pmw_pkg::BLK_W-1:0];
    end
  end

  // Program-memory address: window reads, else external reads in programming mode
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pm_addr <= '0;
      rd_pend_q <= 1'b0;
      ext_pend_q <= 1'b0;
    end else begin
      rd_pend_q <= bus.ds_rd;
      ext_pend_q <= 1'b0;
      if (bus.ds_rd && in_window(bus.ds_addr)) begin
        pm_addr <= {blk_q, bus.ds_addr[pmw_pkg::OFS_W-1:0]};
      end else if (ext_rd && prog_mode && !bus.ds_rd) begin
        // Window reads win; an external read in that cycle is dropped
        pm_addr <= ext_addr;
        ext_pend_q <= 1'b1;
      end
    end
  end

  // Read answer on the data-space bus; window data only for window addresses
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      bus.ds_rdata <= pmw_pkg::RD_NONE;
      bus.ds_rvalid <= 1'b0;
    end else begin
      bus.ds_rvalid <= rd_pend_q;
      if (rd_pend_q && in_window(bus.ds_addr)) begin
        bus.ds_rdata <= pm_rdata;
      end else begin
        // Block select is write only: reads of it give nothing useful
        bus.ds_rdata <= pmw_pkg::RD_NONE;
      end
    end
  end

  // External readout, refused with zero data while protected
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ext_rdata <= '0;
      ext_rvalid <= 1'b0;
    end else begin
      ext_rvalid <= ext_pend_q;
      if (ext_pend_q && !opt_eff[pmw_pkg::OPT_PROTECT]) begin
        ext_rdata <= pm_rdata;
      end else begin
        ext_rdata <= '0;
      end
    end
  end

  // One-time option word. Reset stands for the as-delivered state here;
  // a real part keeps it in non-volatile cells.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      opt_q <= pmw_pkg::OPT_DEFAULT;
      prog_q <= 1'b0;
    end else if (opt_wr && prog_mode && !prog_q && !FACTORY_CODED) begin
      opt_q <= opt_wdata;
      prog_q <= 1'b1;
    end
  end

  // Option readback, only in programming mode and never on mask parts
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      opt_rdata <= '0;
      opt_rvalid <= 1'b0;
      opt_locked <= 1'b0;
    end else begin
      opt_rvalid <= opt_rd;
      opt_locked <= prog_q || FACTORY_CODED;
      if (opt_rd && prog_mode && !FACTORY_CODED) begin
        opt_rdata <= opt_q;
      end else begin
        opt_rdata <= '0;
      end
    end
  end

  // Decoded configuration, registered so every output is a flop
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      stop_allowed <= 1'b0;
      lvd_en <= 1'b0;
      readout_protect <= 1'b0;
      osc_rc <= 1'b0;
      nmi_pullup <= 1'b0;
      wdg_hw <= 1'b0;
      osg_en <= 1'b0;
    end else begin
      stop_allowed <= !wdg_active || (opt_eff[pmw_pkg::OPT_STOP_WDG] && nmi_pin);
      lvd_en <= opt_eff[pmw_pkg::OPT_LVD];
      readout_protect <= opt_eff[pmw_pkg::OPT_PROTECT];
      osc_rc <= opt_eff[pmw_pkg::OPT_OSC_RC];
      nmi_pullup <= opt_eff[pmw_pkg::OPT_NMI_PU];
      wdg_hw <= opt_eff[pmw_pkg::OPT_WDG_HW];
      osg_en <= opt_eff[pmw_pkg::OPT_OSG];
    end
  end
endmodule
`default_nettype wire

//--- verif/pmw_monitor.sv
/*
  Checker on the data-space bus joining the CPU end and the window end.
  Assumes it sits beside the interface and sees core_clk and arst_n.
*/
`default_nettype none
module pmw_monitor (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [7:0] ds_addr,
  input wire logic ds_wr,
  input wire logic ds_rd,
  input wire logic [7:0] ds_wdata,
  input wire logic [7:0] ds_rdata,
  input wire logic ds_rvalid
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  // Address falls in the 64-byte window
  logic in_win;
  assign in_win = (ds_addr >= pmw_pkg::WIN_LO) && (ds_addr <= pmw_pkg::WIN_HI);
  // Answer lands exactly two edges after the read
  sequence s_answer;
    ##2 ds_rvalid;
  endsequence
  property p_rd_answer;
    ds_rd |-> s_answer;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
  property p_no_stray;
    ds_rvalid |-> $past(ds_rd, 2);
  endproperty
  a_no_stray: assert property (p_no_stray) else $error("answer without read");
  property p_miss_zero;
    ds_rd && !in_win |-> ##2 ds_rdata == pmw_pkg::RD_NONE;
  endproperty
  a_miss_zero: assert property (p_miss_zero) else $error("miss gave data");
  property p_idle_zero;
    !ds_rvalid |-> ds_rdata == pmw_pkg::RD_NONE;
  endproperty
  a_idle_zero: assert property (p_idle_zero) else $error("stale read data");
  property p_sel_addr;
    ds_wr |-> ds_addr == pmw_pkg::BLKSEL_ADDR;
  endproperty
  a_sel_addr: assert property (p_sel_addr) else $error("write off register");
  property p_rsvd_zero;
    ds_wr |-> ds_wdata[7:6] == pmw_pkg::BLKSEL_RSVD;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("upper bits set");
  property p_no_rmw;
    // Back-to-back selects are legal; a read in the same cycle, or a read of the register just before, is not
    ds_wr |-> !ds_rd && !($past(ds_rd) && $past(ds_addr) == pmw_pkg::BLKSEL_ADDR);
  endproperty
  a_no_rmw: assert property (p_no_rmw) else $error("register read back");
  property p_rd_in_win;
    ds_rd |-> in_win;
  endproperty
  a_rd_in_win: assert property (p_rd_in_win) else $error("read off window");
  property p_addr_hold;
    ds_rd |=> $stable(ds_addr);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address moved");
endmodule
`default_nettype wire

//--- verif/tb_program_memory_window_config.sv
/*
  Bench joining both window ends; drives commands, options and readout.
  Assumes program memory content is a fixed function of its address.
*/
`default_nettype none
module tb_program_memory_window_config;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0, arst_n = 1'b0, cmd_valid = 1'b0, cmd_sel = 1'b0;
  logic [5:0] cmd_arg = 6'h00, blk_image;
  logic cmd_ready, rsp_valid, rsp_err, opt_rvalid, opt_locked, ext_rvalid;
  logic [7:0] rsp_data, pm_rdata, ext_rdata;
  logic [11:0] pm_addr, ext_addr = 12'hABC;
  logic vpp_high = 1'b0, opt_wr = 1'b0, opt_rd = 1'b0, ext_rd = 1'b0;
  logic wdg_active = 1'b0, nmi_pin = 1'b0;
  logic [15:0] opt_wdata = 16'h0000, opt_rdata;
  logic [5:0] dec; // Decoded option levels
  logic stop_allowed, lvd_en, readout_protect, osc_rc, nmi_pullup, wdg_hw, osg_en;
  logic [15:0] fac_opt_rdata; // Mask-part option readback
  logic [7:0] fac_ext_rdata; // Mask-part external readout
  logic fac_locked, fac_protect; // Mask-part lock and protection
  int n_fail = 0, compares = 0, i;
  pmw_if bus_if ();
  pmw_window pmw_window_inst (.core_clk, .arst_n, .bus(bus_if), .pm_addr, .pm_rdata,
    .vpp_high, .opt_wr, .opt_wdata, .opt_rd, .opt_rdata, .opt_rvalid, .opt_locked,
    .ext_rd, .ext_addr, .ext_rdata, .ext_rvalid, .wdg_active, .nmi_pin, .stop_allowed,
    .lvd_en, .readout_protect, .osc_rc, .nmi_pullup, .wdg_hw, .osg_en);
  pmw_cpu pmw_cpu_inst (.core_clk, .arst_n, .bus(bus_if), .cmd_valid, .cmd_sel, .cmd_arg,
    .cmd_ready, .rsp_valid, .rsp_data, .rsp_err, .blk_image);
  pmw_monitor pmw_monitor_inst (.core_clk, .arst_n, .ds_addr(bus_if.ds_addr),
    .ds_wr(bus_if.ds_wr), .ds_rd(bus_if.ds_rd), .ds_wdata(bus_if.ds_wdata),
    .ds_rdata(bus_if.ds_rdata), .ds_rvalid(bus_if.ds_rvalid));
  // Mask-coded part beside the programmable one; its data-space bus stays idle
  pmw_if fac_if ();
  assign fac_if.ds_addr = 8'h00;
  assign fac_if.ds_wr = 1'b0;
  assign fac_if.ds_rd = 1'b0;
  assign fac_if.ds_wdata = 8'h00;
  pmw_window #(.FACTORY_CODED(1'b1), .MASK_OPTIONS(16'h0080)) pmw_window_fac_inst (
    .core_clk, .arst_n, .bus(fac_if), .pm_addr(), .pm_rdata, .vpp_high, .opt_wr,
    .opt_wdata, .opt_rd, .opt_rdata(fac_opt_rdata), .opt_rvalid(), .opt_locked(fac_locked),
    .ext_rd, .ext_addr, .ext_rdata(fac_ext_rdata), .ext_rvalid(), .wdg_active, .nmi_pin,
    .stop_allowed(), .lvd_en(), .readout_protect(fac_protect), .osc_rc(), .nmi_pullup(),
    .wdg_hw(), .osg_en());
  // Memory pattern mixes block and offset so a swapped field shows
  function automatic logic [7:0] mem(input logic [11:0] a);
    return a[7:0] ^ {2'h0, a[11:6]};
  endfunction
  assign pm_rdata = mem(pm_addr);
  assign dec = {lvd_en, readout_protect, osc_rc, nmi_pullup, wdg_hw, osg_en};
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  task automatic report_and_stop;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // A used-up wait counts as a mismatch and ends the run
  task automatic tmo(input int lim);
    if (i >= lim) begin
      n_fail++;
      report_and_stop();
    end
  endtask
  // One command; reads wait for the response pulse, sampled at a falling edge
  task automatic cmd(input logic sel, input logic [5:0] arg);
    cmd_sel = sel;
    cmd_arg = arg;
    cmd_valid = 1'b1;
    for (i = 0; i < 20 && cmd_ready !== 1'b1; i++) @(negedge core_clk);
    tmo(20);
    @(negedge core_clk);
    cmd_valid = 1'b0;
    for (i = 0; i < 10 && !sel && rsp_valid !== 1'b1; i++) @(negedge core_clk);
    tmo(10);
  endtask
  task automatic opt_read(input logic [15:0] exp);
    opt_rd = 1'b1;
    @(negedge core_clk);
    opt_rd = 1'b0;
    for (i = 0; i < 5 && opt_rvalid !== 1'b1; i++) @(negedge core_clk);
    tmo(5);
    chk("opt_rdata", opt_rdata, exp);
    chk("fac_opt_rdata", fac_opt_rdata, 16'h0000);
  endtask
  task automatic ext_read(input logic [7:0] exp);
    ext_rd = 1'b1;
    @(negedge core_clk);
    ext_rd = 1'b0;
    for (i = 0; i < 5 && ext_rvalid !== 1'b1; i++) @(negedge core_clk);
    tmo(5);
    chk("ext_rdata", {8'h00, ext_rdata}, {8'h00, exp});
    chk("fac_ext_rdata", {8'h00, fac_ext_rdata}, 16'h0000);
  endtask
  task automatic opt_write(input logic [15:0] v);
    opt_wdata = v;
    opt_wr = 1'b1;
    @(negedge core_clk);
    opt_wr = 1'b0;
    repeat (2) @(negedge core_clk);
  endtask
  // Read before any selection is refused
  task automatic t_early;
    cmd(1'b0, 6'h05);
    chk("rsp_err", {15'h0, rsp_err}, 16'h0001);
    $display("t_early done");
  endtask
  // Edge blocks and edge offsets, select followed at once by a read
  task automatic t_window;
    logic [5:0] b[3] = '{6'h00, 6'h01, 6'h3F};
    cmd(1'b1, 6'h15); // Two selects back to back must both be plain writes
    foreach (b[k]) begin
      cmd(1'b1, b[k]);
      chk("blk_image", {10'h0, blk_image}, {10'h0, b[k]});
      cmd(1'b0, 6'h3F - b[k]);
      chk("rsp_data", {8'h0, rsp_data}, {8'h0, mem({b[k], 6'h3F - b[k]})});
      chk("rsp_err", {15'h0, rsp_err}, 16'h0000);
    end
    $display("t_window done");
  endtask
  // One-time option word and its decoded levels; every decoded bit seen at 0 and 1
  task automatic t_options;
    chk("dec", {10'h0, dec}, 16'h0000);
    wdg_active = 1'b1;
    nmi_pin = 1'b1;
    repeat (2) @(negedge core_clk);
    chk("stop", {15'h0, stop_allowed}, 16'h0000);
    opt_write(16'h07DF);
    chk("opt_locked", {15'h0, opt_locked}, 16'h0000);
    opt_read(16'h0000);
    vpp_high = 1'b1;
    ext_read(mem(12'hABC));
    opt_write(16'h07DF);
    chk("opt_locked", {15'h0, opt_locked}, 16'h0001);
    opt_write(16'hF820);
    opt_read(16'h07DF);
    chk("dec", {10'h0, dec}, 16'h003F);
    chk("stop", {15'h0, stop_allowed}, 16'h0001);
    ext_read(8'h00);
    nmi_pin = 1'b0;
    repeat (2) @(negedge core_clk);
    chk("stop", {15'h0, stop_allowed}, 16'h0000);
    wdg_active = 1'b0;
    repeat (2) @(negedge core_clk);
    chk("stop", {15'h0, stop_allowed}, 16'h0001);
    chk("fac_locked", {15'h0, fac_locked}, 16'h0001);
    chk("fac_protect", {15'h0, fac_protect}, 16'h0001);
    $display("t_options done");
  endtask
  initial begin
    repeat (3) @(negedge core_clk);
    arst_n = 1'b1;
    @(negedge core_clk);
    t_early();
    t_window();
    t_options();
    report_and_stop();
  end
endmodule
`default_nettype wire
